// file: hdl/cmc_pkg.sv
// Package of the CAN mode-control block: register map, field layout, reset values, timing.
// Assumes a single 20 MHz core clock and an APB register bus with 32-bit data.
// Operation
// - Mode control register takes writes only when init request and acknowledge are both one.
// - Enable bit writes once in normal mode, repeatedly in special mode, only during init.
// - Mode control bit 7 disables the controller at zero, enables it at one.
// - Mode control bit 6 picks oscillator clock at zero, bus clock at one.
// - Loopback bit 5 feeds transmit stream to receiver, ignores receive pin, transmit pin recessive.
// - Loopback treats own frame as remote, ignores acknowledge slot, raises transmit and receive events.
// - Listen-only bit 4 receives matching frames, never sends acknowledge or error frames.
// - Listen-only freezes error counters and blocks all frame transmission.
// - Bit 3 selects automatic bus-off recovery at zero, software-requested recovery at one.
// - With wake enabled, bit 2 picks any dominant level or filtered dominant pulse wake.
// - Bit 1 is device-driven sleep acknowledge; sleep active when request and acknowledge both set.
// - With wake enabled, bus activity during sleep makes the device clear sleep acknowledge.
// - Bit 0 is device-driven init acknowledge; init active when request and acknowledge both set.
// - Mode control, timing, acceptance control, code and mask registers writable only during init.
// - Timing register 0 at offset 0x0002 holds jump width 7:6, prescaler 5:0, reset zero; the code maps it at 0x008.
// - Setting init request enters init mode, then device sets init acknowledge.
// - Sleep granted only when bus idle: no reception and all transmit buffers empty.
package cmc_pkg;
   localparam logic [11:0] CMC_OFF_CTL0 = 12'h000;
   localparam logic [11:0] CMC_OFF_CTL1 = 12'h004;
   localparam logic [11:0] CMC_OFF_BTR0 = 12'h008;
   localparam logic [11:0] CMC_OFF_BTR1 = 12'h00C;
   localparam logic [11:0] CMC_OFF_IDAC = 12'h010;
   localparam logic [11:0] CMC_OFF_IDAR = 12'h040;
   localparam logic [11:0] CMC_OFF_IDMR = 12'h060;
   localparam logic [11:0] CMC_OFF_STAT = 12'h080;
   localparam int CMC_IDX_BTR0 = 2;
   localparam int CMC_NACC = 8;
   localparam logic [7:0] CMC_CTL1_RST = 8'h11;
   localparam logic [3:0] CMC_CTL0_RST = 4'h1;
   localparam logic [7:0] CMC_ZERO8 = 8'h00;
   localparam logic [7:0] CMC_IDAC_MASK = 8'h30;
   localparam int CMC_CTL0_INITIALIZATION_REQUEST = 0;
   localparam int CMC_CTL0_SLEEP_REQUEST = 1;
   localparam int CMC_CTL0_WAKE = 2;
   localparam int CMC_CTL0_BOREQ = 3;
   localparam real CMC_CLK_MHZ = 20.0;
   localparam real CMC_WAKE_US = 2.0;
   localparam int CMC_WAKE_CYC = int'($floor(CMC_WAKE_US * CMC_CLK_MHZ));
   localparam int CMC_WAKE_W = 8;
   localparam int CMC_INIT_LAT = 2;
   typedef struct packed {
      logic controllerEnable;
      logic clockSourceSelect;
      logic internalLoopbackTest;
      logic listenOnly;
      logic busoffRecoverySelect;
      logic wakeFilterSelect;
      logic sleepAcknowledge;
      logic initializationAcknowledge;
   } cmc_ctl1_type;
   typedef struct packed {
      logic [1:0] syncJumpWidth;
      logic [5:0] baudPrescaler;
   } cmc_btr0_type;
   typedef struct packed {
      logic txActive;
      logic txErrorFrame;
      logic txAck;
      logic countErrors;
      logic rxFromLoop;
      logic ignoreAckSlot;
      logic loopTxRxEvents;
      logic busoffAutoRecover;
   } cmc_core_type;
   typedef enum logic [2:0] {
      CMC_RUN = 3'b001,
      CMC_INIT = 3'b010,
      CMC_SLEEP = 3'b100
   } cmc_mode_type;
endpackage

// file: hdl/cmc_wake_filter.sv
// Wake-up detector for the CAN receive line during sleep.
// Assumes the receive level is synchronous to core_clk; dominant is logic 0.
`timescale 1ns/1ns
`default_nettype none
module cmc_wake_filter
   import cmc_pkg::*;
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic armed,
   input wire logic filterOn,
   input wire logic busLevel,
   output logic wakeHit
);
   logic [CMC_WAKE_W-1:0] cnt;
   logic [CMC_WAKE_W-1:0] next_cnt;
   always_comb begin
      next_cnt = '0;
      if (armed && !busLevel && cnt != CMC_WAKE_W'(CMC_WAKE_CYC)) begin
         next_cnt = cnt + 1'b1;
      end else if (armed && !busLevel) begin
         next_cnt = cnt;
      end
   end
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         cnt <= '0;
      end else begin
         cnt <= next_cnt;
      end
   end
   // Short glitches never reach the count when filtering is on
   assign wakeHit = armed && !busLevel && (!filterOn || cnt == CMC_WAKE_W'(CMC_WAKE_CYC));
endmodule
`default_nettype wire

// file: hdl/cmc_mode_ctrl.sv
// Mode control and bit-timing registers of a CAN controller, APB slave.
// Assumes APB master on core_clk; protocol engine sits outside and reads the coreCtl controls.
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module cmc_mode_ctrl
   import cmc_pkg::*;
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic specialMode,
   input wire logic busIdleRx,
   input wire logic txBuffersEmpty,
   input wire logic bus_receive_pin,
   input wire logic engineTx,
   output logic bus_transmit_pin,
   output logic engineRx,
   output cmc_core_type coreCtl,
   output logic controllerOn,
   output logic clockSel,
   output logic [7:0] bitTimingPrescaleJump,
   output logic [7:0] bitTimingSegments
);
   cmc_ctl1_type ctl1, next_ctl1;
   cmc_btr0_type btr0, next_btr0;
   logic [7:0] btr1, next_btr1;
   logic [7:0] idac, next_idac;
   logic [7:0] idar [CMC_NACC];
   logic [7:0] idmr [CMC_NACC];
   logic [3:0] ctl0, next_ctl0;
   logic enableLocked, next_enableLocked;
   logic [1:0] initCnt, next_initCnt;
   cmc_mode_type mode, next_mode;
   logic [31:0] next_prdata;
   logic wakeHit;
   logic wrEn, rdEn, initActive, sleepActive;
   cmc_ctl1_type wrCtl1;

   function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
      hit = (a == off);
   endfunction
   function automatic logic inArr(input logic [11:0] a, input logic [11:0] base);
      inArr = (a >= base) && (a < base + 12'(CMC_NACC * 4));
   endfunction

   assign wrEn = psel && penable && pwrite;
   // Read data are captured in the setup phase so they stand through the access phase
   assign rdEn = psel && !penable && !pwrite;
   assign wrCtl1 = cmc_ctl1_type'(pwdata[7:0]);
   assign pready = 1'b1;
   assign initActive = ctl0[CMC_CTL0_INITIALIZATION_REQUEST] && ctl1.initializationAcknowledge;
   assign sleepActive = ctl0[CMC_CTL0_SLEEP_REQUEST] && ctl1.sleepAcknowledge;

   always_comb begin
      pslverr = 1'b0;
      if (psel && penable) begin
         pslverr = !(hit(paddr, CMC_OFF_CTL0) || hit(paddr, CMC_OFF_CTL1) || hit(paddr, CMC_OFF_BTR0)
            || hit(paddr, CMC_OFF_BTR1) || hit(paddr, CMC_OFF_IDAC) || inArr(paddr, CMC_OFF_IDAR)
            || inArr(paddr, CMC_OFF_IDMR) || hit(paddr, CMC_OFF_STAT));
      end
   end

   cmc_wake_filter i_cmc_wake_filter (
      .core_clk(core_clk),
      .nrst(nrst),
      .armed(sleepActive && ctl0[CMC_CTL0_WAKE]),
      .filterOn(ctl1.wakeFilterSelect),
      .busLevel(bus_receive_pin),
      .wakeHit(wakeHit)
   );

   // Mode requests and handshake flags
   always_comb begin
      next_ctl0 = ctl0;
      next_ctl1 = ctl1;
      next_btr0 = btr0;
      next_btr1 = btr1;
      next_idac = idac;
      next_enableLocked = enableLocked;
      next_initCnt = initCnt;
      next_mode = mode;
      if (wrEn && hit(paddr, CMC_OFF_CTL0)) begin
         // Init and sleep requests cannot be withdrawn before they are acknowledged
         next_ctl0[CMC_CTL0_INITIALIZATION_REQUEST] = pwdata[CMC_CTL0_INITIALIZATION_REQUEST] || (ctl0[CMC_CTL0_INITIALIZATION_REQUEST] && !initActive);
         next_ctl0[CMC_CTL0_SLEEP_REQUEST] = pwdata[CMC_CTL0_SLEEP_REQUEST] || (ctl0[CMC_CTL0_SLEEP_REQUEST] && !sleepActive);
         next_ctl0[CMC_CTL0_WAKE] = pwdata[CMC_CTL0_WAKE];
         next_ctl0[CMC_CTL0_BOREQ] = pwdata[CMC_CTL0_BOREQ];
      end
      // Acknowledge bits are kept: software cannot write them
      if (wrEn && hit(paddr, CMC_OFF_CTL1) && initActive) begin
         next_ctl1.clockSourceSelect = wrCtl1.clockSourceSelect;
         next_ctl1.internalLoopbackTest = wrCtl1.internalLoopbackTest;
         next_ctl1.listenOnly = wrCtl1.listenOnly;
         next_ctl1.busoffRecoverySelect = wrCtl1.busoffRecoverySelect;
         next_ctl1.wakeFilterSelect = wrCtl1.wakeFilterSelect;
         if (specialMode || !enableLocked) begin
            next_ctl1.controllerEnable = wrCtl1.controllerEnable;
            next_enableLocked = !specialMode;
         end
      end
      if (wrEn && initActive) begin
         if (hit(paddr, CMC_OFF_BTR0)) begin
            next_btr0 = cmc_btr0_type'(pwdata[7:0]);
         end
         if (hit(paddr, CMC_OFF_BTR1)) begin
            next_btr1 = pwdata[7:0];
         end
         if (hit(paddr, CMC_OFF_IDAC)) begin
            next_idac = pwdata[7:0] & CMC_IDAC_MASK;
         end
      end
      unique case (mode)
         CMC_RUN: begin
            next_initCnt = '0;
            if (ctl0[CMC_CTL0_INITIALIZATION_REQUEST]) begin
               next_mode = CMC_INIT;
            end else if (ctl0[CMC_CTL0_SLEEP_REQUEST] && busIdleRx && txBuffersEmpty) begin
               next_mode = CMC_SLEEP;
               next_ctl1.sleepAcknowledge = 1'b1;
            end
         end
         CMC_INIT: begin
            // Acknowledge only after the engine had time to abort
            if (initCnt != 2'(CMC_INIT_LAT)) begin
               next_initCnt = initCnt + 1'b1;
            end else begin
               next_ctl1.initializationAcknowledge = 1'b1;
            end
            if (!ctl0[CMC_CTL0_INITIALIZATION_REQUEST] && ctl1.initializationAcknowledge) begin
               next_ctl1.initializationAcknowledge = 1'b0;
               next_mode = CMC_RUN;
            end
         end
         CMC_SLEEP: begin
            if (ctl0[CMC_CTL0_INITIALIZATION_REQUEST]) begin
               next_ctl1.sleepAcknowledge = 1'b0;
               next_mode = CMC_INIT;
            end else if (wakeHit) begin
               next_ctl1.sleepAcknowledge = 1'b0;
               next_ctl0[CMC_CTL0_SLEEP_REQUEST] = 1'b0;
               next_mode = CMC_RUN;
            end else if (!ctl0[CMC_CTL0_SLEEP_REQUEST]) begin
               next_ctl1.sleepAcknowledge = 1'b0;
               next_mode = CMC_RUN;
            end
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         ctl0 <= CMC_CTL0_RST;
         ctl1 <= cmc_ctl1_type'(CMC_CTL1_RST);
         btr0 <= cmc_btr0_type'(CMC_ZERO8);
         btr1 <= CMC_ZERO8;
         idac <= CMC_ZERO8;
         enableLocked <= 1'b0;
         initCnt <= '0;
         mode <= CMC_INIT;
      end else begin
         ctl0 <= next_ctl0;
         ctl1 <= next_ctl1;
         btr0 <= next_btr0;
         btr1 <= next_btr1;
         idac <= next_idac;
         enableLocked <= next_enableLocked;
         initCnt <= next_initCnt;
         mode <= next_mode;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < CMC_NACC; gi++) begin : accRegs
         logic [7:0] next_code, next_mask;
         always_comb begin
            next_code = idar[gi];
            next_mask = idmr[gi];
            if (wrEn && initActive && hit(paddr, CMC_OFF_IDAR + 12'(gi * 4))) begin
               next_code = pwdata[7:0];
            end
            if (wrEn && initActive && hit(paddr, CMC_OFF_IDMR + 12'(gi * 4))) begin
               next_mask = pwdata[7:0];
            end
         end
         always_ff @(posedge core_clk or negedge nrst) begin
            if (!nrst) begin
               idar[gi] <= CMC_ZERO8;
               idmr[gi] <= CMC_ZERO8;
            end else begin
               idar[gi] <= next_code;
               idmr[gi] <= next_mask;
            end
         end
      end
   endgenerate

   // Read data
   always_comb begin
      next_prdata = prdata;
      if (rdEn) begin
         next_prdata = '0;
         if (hit(paddr, CMC_OFF_CTL0)) next_prdata[3:0] = ctl0;
         if (hit(paddr, CMC_OFF_CTL1)) next_prdata[7:0] = ctl1;
         if (hit(paddr, CMC_OFF_BTR0)) next_prdata[7:0] = btr0;
         if (hit(paddr, CMC_OFF_BTR1)) next_prdata[7:0] = btr1;
         if (hit(paddr, CMC_OFF_IDAC)) next_prdata[7:0] = idac;
         if (hit(paddr, CMC_OFF_STAT)) next_prdata[2:0] = mode;
         for (int k = 0; k < CMC_NACC; k++) begin
            if (hit(paddr, CMC_OFF_IDAR + 12'(k * 4))) next_prdata[7:0] = idar[k];
            if (hit(paddr, CMC_OFF_IDMR + 12'(k * 4))) next_prdata[7:0] = idmr[k];
         end
      end
   end
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         prdata <= '0;
      end else begin
         prdata <= next_prdata;
      end
   end

   // Controls toward the protocol engine
   always_comb begin
      coreCtl.txActive = ctl1.controllerEnable && !ctl1.listenOnly && mode == CMC_RUN;
      coreCtl.txErrorFrame = !ctl1.listenOnly;
      coreCtl.txAck = !ctl1.listenOnly && !ctl1.internalLoopbackTest;
      coreCtl.countErrors = !ctl1.listenOnly;
      coreCtl.rxFromLoop = ctl1.internalLoopbackTest;
      coreCtl.ignoreAckSlot = ctl1.internalLoopbackTest;
      coreCtl.loopTxRxEvents = ctl1.internalLoopbackTest;
      coreCtl.busoffAutoRecover = !ctl1.busoffRecoverySelect || ctl0[CMC_CTL0_BOREQ];
   end
   // Receiver gets the own stream in loopback; pin held recessive then and in init
   assign engineRx = ctl1.internalLoopbackTest ? engineTx : bus_receive_pin;
   assign bus_transmit_pin = (ctl1.internalLoopbackTest || !coreCtl.txActive) ? 1'b1 : engineTx;
   assign controllerOn = ctl1.controllerEnable;
   assign clockSel = ctl1.clockSourceSelect;
   assign bitTimingPrescaleJump = btr0;
   assign bitTimingSegments = btr1;
endmodule
`default_nettype wire

// file: dv/cmc_mode_ctrl_monitor.sv
// Checker of the CAN mode-control block, bound to its ports.
// Assumes one clock core_clk and active-low asynchronous reset nrst.
`timescale 1ns/1ns
`default_nettype none
module cmc_mode_ctrl_monitor
   import cmc_pkg::*;
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic specialMode,
   input wire logic busIdleRx,
   input wire logic txBuffersEmpty,
   input wire logic bus_receive_pin,
   input wire logic engineTx,
   input wire logic bus_transmit_pin,
   input wire logic engineRx,
   input wire cmc_core_type coreCtl,
   input wire logic controllerOn,
   input wire logic clockSel,
   input wire logic [7:0] bitTimingPrescaleJump,
   input wire logic [7:0] bitTimingSegments
);
   logic wrCtl1Q, wrBtr0Q, rdQ;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   // Access kinds of the last edge; $past is kept to plain signals
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         wrCtl1Q <= 1'b0;
         wrBtr0Q <= 1'b0;
         rdQ <= 1'b0;
      end else begin
         wrCtl1Q <= psel && penable && pwrite && paddr == CMC_OFF_CTL1;
         wrBtr0Q <= psel && penable && pwrite && paddr == CMC_OFF_BTR0;
         rdQ <= psel && !penable && !pwrite;
      end
   end
   sequence loopPath;
      engineRx == engineTx && bus_transmit_pin;
   endsequence
   sequence pinFollows;
      bus_transmit_pin == engineTx && engineRx == bus_receive_pin;
   endsequence
   loop_route_a: assert property (coreCtl.rxFromLoop |-> loopPath)
      else $error("loopback path broken");
   loop_events_a: assert property (coreCtl.rxFromLoop |-> coreCtl.ignoreAckSlot && coreCtl.loopTxRxEvents)
      else $error("loopback controls missing");
   rx_direct_a: assert property (!coreCtl.rxFromLoop |-> engineRx == bus_receive_pin)
      else $error("receive pin not routed");
   tx_quiet_a: assert property (!coreCtl.txActive |-> bus_transmit_pin)
      else $error("transmit pin not recessive");
   tx_drive_a: assert property (coreCtl.txActive && !coreCtl.rxFromLoop |-> pinFollows)
      else $error("transmit pin not driven");
   off_idle_a: assert property (!controllerOn |-> !coreCtl.txActive)
      else $error("disabled controller transmits");
   ctl1_write_a: assert property ($changed(controllerOn) || $changed(clockSel) |-> wrCtl1Q)
      else $error("mode bits changed without write");
   btr0_write_a: assert property ($changed(bitTimingPrescaleJump) |-> wrBtr0Q)
      else $error("timing changed without write");
   rdata_hold_a: assert property ($changed(prdata) |-> rdQ)
      else $error("read data moved without read");
   reset_vals_a: assert property ($rose(nrst) |-> bitTimingPrescaleJump == 8'h00 && !controllerOn)
      else $error("bad value after reset");
endmodule
bind cmc_mode_ctrl cmc_mode_ctrl_monitor i_cmc_mode_ctrl_monitor (.*);
`default_nettype wire

// file: dv/cmc_bus_node.sv
// Model of the other nodes on the CAN bus: dominant pulses on request.
// Assumes start is a one-cycle pulse on core_clk.
`timescale 1ns/1ns
`default_nettype none
module cmc_bus_node (
   input wire logic core_clk,
   input wire logic start,
   input wire logic [7:0] pulseLen,
   output logic busLine
);
   logic [7:0] left;
   initial left = 8'h00;
   always @(posedge core_clk) begin
      if (start) begin
         left <= pulseLen;
      end else if (left != 8'h00) begin
         left <= left - 8'h01;
      end
   end
   // Dominant is 0; a released bus floats back to recessive
   assign busLine = (left == 8'h00);
endmodule
`default_nettype wire

// file: dv/tb_cmc_mode_ctrl.sv
// Testbench of the CAN mode-control block: APB tasks and checked scenarios.
// Assumes an APB slave that may add wait states; read data stand while pready is high.
`timescale 1ns/1ns
`default_nettype none
module tb_cmc_mode_ctrl;
   import cmc_pkg::*;
   logic core_clk, nrst, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic specialMode, busIdleRx, txBuffersEmpty, bus_receive_pin, engineTx;
   logic bus_transmit_pin, engineRx, controllerOn, clockSel, start, errSeen;
   cmc_core_type coreCtl;
   logic [7:0] bitTimingPrescaleJump, bitTimingSegments, pulseLen, q;
   int mismatches, n_checks, cyc;
   cmc_mode_ctrl i_cmc_mode_ctrl (.*);
   cmc_bus_node i_cmc_bus_node (.core_clk(core_clk), .start(start), .pulseLen(pulseLen), .busLine(bus_receive_pin));
   always #25 core_clk = ~core_clk;
   task automatic final_report;
      if (mismatches == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Bounded run; a hang is a mismatch
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 6000) begin
         mismatches++;
         final_report();
      end
   end
   task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
      n_checks++;
      if (s !== e) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [7:0] r);
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h00_0000, d};
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      errSeen = pslverr;
      r = prdata[7:0];
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic pulse(input logic [7:0] n);
      @(posedge core_clk);
      start <= 1'b1;
      pulseLen <= n;
      @(posedge core_clk);
      start <= 1'b0;
      repeat (n + 20) @(posedge core_clk);
   endtask
   initial begin
      core_clk = 0; nrst = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
      specialMode = 0; busIdleRx = 1; txBuffersEmpty = 1; engineTx = 1; start = 0; pulseLen = 0;
      mismatches = 0; n_checks = 0; cyc = 0;
      repeat (5) @(posedge core_clk);
      nrst <= 1'b1;
      apb(0, CMC_OFF_CTL1, 0, q); chk("ctl1 reset", q, 8'h11);
      apb(0, CMC_OFF_BTR0, 0, q); chk("btr0 reset", q, 8'h00);
      apb(1, CMC_OFF_BTR0, 8'hC5, q);
      apb(0, CMC_OFF_BTR0, 0, q); chk("btr0", q, 8'hC5);
      chk("btr0 out", bitTimingPrescaleJump, 8'hC5);
      apb(1, CMC_OFF_BTR1, 8'h3A, q); chk("btr1 out", bitTimingSegments, 8'h3A);
      apb(1, CMC_OFF_IDAC, 8'hFF, q);
      apb(0, CMC_OFF_IDAC, 0, q); chk("idac", q, CMC_IDAC_MASK);
      apb(1, CMC_OFF_IDMR + 12'h01C, 8'hA5, q);
      apb(0, CMC_OFF_IDMR + 12'h01C, 0, q); chk("mask 7", q, 8'hA5);
      apb(1, CMC_OFF_CTL1, 8'hFE, q);
      apb(0, CMC_OFF_CTL1, 0, q); chk("ctl1 ro bits", q, 8'hFD);
      chk("enable", 8'(controllerOn), 8'h01);
      chk("clock src", 8'(clockSel), 8'h01);
      engineTx <= 1'b0;
      @(posedge core_clk);
      chk("loop rx", 8'(engineRx), 8'h00);
      chk("loop tx pin", 8'(bus_transmit_pin), 8'h01);
      chk("loop ack", 8'(coreCtl.ignoreAckSlot), 8'h01);
      chk("loop events", 8'(coreCtl.loopTxRxEvents), 8'h01);
      apb(1, CMC_OFF_CTL1, 8'h00, q);
      apb(0, CMC_OFF_CTL1, 0, q); chk("enable once", q, 8'h81);
      specialMode <= 1'b1;
      apb(1, CMC_OFF_CTL1, 8'h08, q);
      apb(0, CMC_OFF_CTL1, 0, q); chk("enable again", q, 8'h09);
      chk("manual recovery", 8'(coreCtl.busoffAutoRecover), 8'h00);
      apb(1, CMC_OFF_CTL1, 8'h84, q);
      chk("auto recovery", 8'(coreCtl.busoffAutoRecover), 8'h01);
      chk("osc clock", 8'(clockSel), 8'h00);
      apb(1, CMC_OFF_CTL0, 8'h00, q);
      apb(0, CMC_OFF_CTL1, 0, q); chk("init left", q, 8'h84);
      chk("tx follows", 8'(bus_transmit_pin), 8'h00);
      apb(1, CMC_OFF_CTL1, 8'h94, q);
      apb(1, CMC_OFF_BTR0, 8'h11, q);
      apb(0, CMC_OFF_CTL1, 0, q); chk("ctl1 locked", q, 8'h84);
      apb(0, CMC_OFF_BTR0, 0, q); chk("btr0 locked", q, 8'hC5);
      apb(0, CMC_OFF_STAT, 0, q); chk("run state", q, 8'h01);
      apb(1, 12'hFFC, 8'h5A, q); chk("unmapped err", 8'(errSeen), 8'h01);
      apb(0, 12'hFFC, 0, q); chk("unmapped read", q, 8'h00);
      // Busy receiver must hold the sleep request off
      busIdleRx <= 1'b0;
      apb(1, CMC_OFF_CTL0, 8'h06, q);
      apb(0, CMC_OFF_CTL1, 0, q); chk("sleep held", q, 8'h84);
      busIdleRx <= 1'b1;
      apb(0, CMC_OFF_CTL1, 0, q); chk("sleep ack", q, 8'h86);
      chk("sleep tx pin", 8'(bus_transmit_pin), 8'h01);
      pulse(8'h0A);
      apb(0, CMC_OFF_CTL1, 0, q); chk("short pulse", q, 8'h86);
      pulse(8'h3C);
      apb(0, CMC_OFF_CTL1, 0, q); chk("woken", q, 8'h84);
      apb(0, CMC_OFF_CTL0, 0, q); chk("request cleared", q, 8'h04);
      apb(1, CMC_OFF_CTL0, 8'h05, q);
      repeat (4) @(posedge core_clk);
      apb(0, CMC_OFF_CTL1, 0, q); chk("init again", q, 8'h85);
      apb(1, CMC_OFF_CTL1, 8'h94, q);
      apb(1, CMC_OFF_CTL0, 8'h04, q);
      @(posedge core_clk);
      chk("listen pin", 8'(bus_transmit_pin), 8'h01);
      chk("listen ack", 8'(coreCtl.txAck), 8'h00);
      chk("listen errs", 8'(coreCtl.countErrors), 8'h00);
      chk("listen errframe", 8'(coreCtl.txErrorFrame), 8'h00);
      chk("listen tx", 8'(coreCtl.txActive), 8'h00);
      // Unfiltered wake: any dominant level ends sleep
      apb(1, CMC_OFF_CTL0, 8'h05, q);
      repeat (4) @(posedge core_clk);
      apb(1, CMC_OFF_CTL1, 8'h80, q);
      apb(1, CMC_OFF_CTL0, 8'h06, q);
      apb(0, CMC_OFF_CTL1, 0, q); chk("sleep again", q, 8'h82);
      pulse(8'h02);
      apb(0, CMC_OFF_CTL1, 0, q); chk("unfiltered wake", q, 8'h80);
      // Second reset in mid-run restores the reset values
      nrst <= 1'b0;
      repeat (2) @(posedge core_clk);
      nrst <= 1'b1;
      apb(0, CMC_OFF_BTR0, 0, q); chk("btr0 rereset", q, 8'h00);
      apb(0, CMC_OFF_CTL1, 0, q); chk("ctl1 rereset", q, CMC_CTL1_RST);
      final_report();
   end
endmodule
`default_nettype wire
